// [rtl/iotpc_top.v]
/*
 * Internal oscillator tuning, low-frequency source select, 4x multiplier
 * gating and glitch-free device clock source switching, with an APB slave.
 * Assumes all inputs synchronous to clk; oscillators appear as one-cycle
 * tick enables, the internal ones modelled by accumulators and dividers.
 */
`timescale 1ns/100ps
`include "iotpc_defines.vh"

module iotpc_top #(
	parameter SLOW_DIV = `IOTPC_SLOW_DIV,
	parameter SETTLE_CYC = `IOTPC_SETTLE_CYC
) (
	input wire clk, // 200 MHz system clock
	input wire rst_n, // Asynchronous reset
	input wire psel, // APB select
	input wire penable, // APB enable
	input wire pwrite, // APB direction
	input wire [7:0] paddr, // APB byte address
	input wire [31:0] pwdata, // APB write data
	output reg [31:0] prdata, // APB read data
	output reg pready, // APB ready
	output reg pslverr, // APB error on unmapped address
	input wire [3:0] primary_clock_cfg, // Primary oscillator configuration
	input wire primary_osc_tick, // Primary oscillator tick
	input wire secondary_timer_osc_tick, // Secondary oscillator tick
	input wire secondary_osc_en, // Secondary oscillator enabled
	output reg dev_clk_tick, // Device clock enable
	output reg feature_clk_tick, // Special feature clock enable
	output reg sec_clk_tick, // Secondary clock enable
	output reg multiplier_on // Multiplier active
);

	localparam [2:0] SW_RUN = 3'b001;
	localparam [2:0] SW_OLD = 3'b010;
	localparam [2:0] SW_NEW = 3'b100;

	function [7:0] post_mask;
		input [2:0] sel;
		begin
			case (sel)
				3'h7: post_mask = 8'h00;
				3'h6: post_mask = 8'h01;
				3'h5: post_mask = 8'h03;
				3'h4: post_mask = 8'h07;
				3'h3: post_mask = 8'h0f;
				3'h2: post_mask = 8'h1f;
				3'h1: post_mask = 8'h3f;
				default: post_mask = 8'hff;
			endcase
		end
	endfunction

	function [5:0] half_up;
		input [5:0] m;
		begin
			half_up = (m + 6'h01) >> 1;
		end
	endfunction

	reg low_freq_source_sel;
	reg multiplier_enable;
	reg [4:0] freq_trim_field;
	reg [4:0] trim_eff;
	reg [2:0] internal_freq_sel;
	reg [1:0] system_clock_sel;
	reg [15:0] fast_acc;
	reg [15:0] mult_acc;
	reg [7:0] post_cnt;
	reg mult_half;
	reg [12:0] slow_cnt;
	reg [3:0] trim_ticks;
	reg [17:0] settle_cnt;
	reg [2:0] sw_state;
	reg [1:0] active_src;
	reg [1:0] new_src;
	reg [1:0] sw_cnt;

	wire access = psel & penable & pready;
	wire wr = access & pwrite;
	wire mult_avail = (primary_clock_cfg == `IOTPC_CFG_INT_A) ||
		(primary_clock_cfg == `IOTPC_CFG_INT_B);
	wire fsel_mult_ok = (internal_freq_sel == `IOTPC_FSEL_8MHZ) ||
		(internal_freq_sel == `IOTPC_FSEL_4MHZ);
	wire mult_active = multiplier_enable & mult_avail & fsel_mult_ok;

	// Signed trim scales the fast increment; slow source is untouched
	wire [15:0] trim_ext = {{11{trim_eff[4]}}, trim_eff};
	wire [15:0] trim_off = trim_ext * `IOTPC_TRIM_STEP;
	wire [15:0] fast_inc = `IOTPC_FAST_INC + trim_off;
	wire [15:0] mult_inc = fast_inc * `IOTPC_MULT_FACTOR;
	wire [16:0] fast_sum = {1'b0, fast_acc} + {1'b0, fast_inc};
	wire [16:0] mult_sum = {1'b0, mult_acc} + {1'b0, mult_inc};
	wire fast_tick = fast_sum[16];
	wire mult_tick = mult_sum[16];
	wire slow_tick = (slow_cnt == SLOW_DIV[12:0] - 13'h0001);

	wire [7:0] mask = post_mask(internal_freq_sel);
	wire post_tick = fast_tick && ((post_cnt & mask) == mask);
	reg int_tick;
	always @* begin
		if (mult_active) begin
			// 8 MHz x4 gives 32 MHz, 4 MHz x4 gives 16 MHz
			if (internal_freq_sel == `IOTPC_FSEL_8MHZ) begin
				int_tick = mult_tick;
			end else begin
				int_tick = mult_tick & mult_half;
			end
		end else if (internal_freq_sel == `IOTPC_FSEL_31KHZ) begin
			int_tick = low_freq_source_sel ? post_tick : slow_tick;
		end else begin
			int_tick = post_tick;
		end
	end

	wire sec_tick = secondary_timer_osc_tick & secondary_osc_en;
	wire pri_tick = mult_avail ? int_tick : primary_osc_tick;

	function src_tick;
		input [1:0] s;
		input p;
		input c;
		input i;
		begin
			case (s)
				`IOTPC_SRC_PRI: src_tick = p;
				`IOTPC_SRC_SEC: src_tick = c;
				default: src_tick = i;
			endcase
		end
	endfunction

	// Secondary request without a running secondary is ignored
	reg [1:0] want_src;
	always @* begin
		if (system_clock_sel[1]) begin
			want_src = `IOTPC_SRC_INT;
		end else if (system_clock_sel[0]) begin
			want_src = secondary_osc_en ? `IOTPC_SRC_SEC : active_src;
		end else begin
			want_src = `IOTPC_SRC_PRI;
		end
	end

	wire old_tick = src_tick(active_src, pri_tick, sec_tick, int_tick);
	wire nxt_tick = src_tick(new_src, pri_tick, sec_tick, int_tick);

	// Trim step toward target, half the gap rounded up per own tick
	wire [5:0] trim_diff = {freq_trim_field[4], freq_trim_field} - {trim_eff[4], trim_eff};
	wire [5:0] trim_mag = trim_diff[5] ? (6'h00 - trim_diff) : trim_diff;
	wire [5:0] trim_step = half_up(trim_mag);
	wire [5:0] trim_up = {trim_eff[4], trim_eff} + trim_step;
	wire [5:0] trim_dn = {trim_eff[4], trim_eff} - trim_step;

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			low_freq_source_sel <= 1'b0;
			multiplier_enable <= 1'b0;
			freq_trim_field <= 5'h00;
			internal_freq_sel <= `IOTPC_FSEL_RESET;
			system_clock_sel <= `IOTPC_SYSSEL_RESET;
		end else begin
			if (wr && paddr == `IOTPC_OFF_TUNING) begin
				low_freq_source_sel <= pwdata[`IOTPC_LFSRC_BIT];
				multiplier_enable <= pwdata[`IOTPC_MULEN_BIT] & mult_avail;
				freq_trim_field <= pwdata[`IOTPC_TRIM_MSB:0];
			end else if (!mult_avail) begin
				multiplier_enable <= 1'b0;
			end
			if (wr && paddr == `IOTPC_OFF_OSCCTL) begin
				internal_freq_sel <= pwdata[`IOTPC_FSEL_MSB:`IOTPC_FSEL_LSB];
				system_clock_sel <= pwdata[`IOTPC_SYSSEL_MSB:0];
			end
		end
	end

	// Code keeps running while the trim settles; no completion flag exists
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			trim_eff <= 5'h00;
			trim_ticks <= 4'h0;
			settle_cnt <= 18'h00000;
		end else if (wr && paddr == `IOTPC_OFF_TUNING) begin
			trim_ticks <= 4'h0;
			settle_cnt <= 18'h00000;
		end else if (trim_eff != freq_trim_field) begin
			settle_cnt <= settle_cnt + 18'h00001;
			if (settle_cnt >= SETTLE_CYC[17:0] - 18'h00001 ||
				trim_ticks >= `IOTPC_TRIM_TICKS - 1) begin
				trim_eff <= freq_trim_field;
			end else if (fast_tick) begin
				trim_ticks <= trim_ticks + 4'h1;
				trim_eff <= trim_diff[5] ? trim_dn[4:0] : trim_up[4:0];
			end
		end
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			fast_acc <= 16'h0000;
			mult_acc <= 16'h0000;
			post_cnt <= 8'h00;
			mult_half <= 1'b0;
			slow_cnt <= 13'h0000;
		end else begin
			fast_acc <= fast_sum[15:0];
			mult_acc <= mult_sum[15:0];
			if (fast_tick) begin
				post_cnt <= post_cnt + 8'h01;
			end
			if (mult_tick) begin
				mult_half <= ~mult_half;
			end
			slow_cnt <= slow_tick ? 13'h0000 : slow_cnt + 13'h0001;
		end
	end

	// Glitch-free switch: pause output across old and new source ticks
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sw_state <= SW_RUN;
			active_src <= `IOTPC_SRC_PRI;
			new_src <= `IOTPC_SRC_PRI;
			sw_cnt <= 2'h0;
		end else begin
			case (sw_state)
				SW_RUN: begin
					if (want_src != active_src) begin
						new_src <= want_src;
						sw_cnt <= 2'h0;
						sw_state <= SW_OLD;
					end
				end
				SW_OLD: begin
					if (old_tick) begin
						if (sw_cnt == `IOTPC_SW_OLD_TICKS - 1) begin
							sw_cnt <= 2'h0;
							sw_state <= SW_NEW;
						end else begin
							sw_cnt <= sw_cnt + 2'h1;
						end
					end
				end
				SW_NEW: begin
					if (nxt_tick) begin
						if (sw_cnt == `IOTPC_SW_NEW_TICKS - 1) begin
							active_src <= new_src;
							sw_state <= SW_RUN;
						end else begin
							sw_cnt <= sw_cnt + 2'h1;
						end
					end
				end
				default: begin
					sw_state <= SW_RUN;
				end
			endcase
		end
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			dev_clk_tick <= 1'b0;
			feature_clk_tick <= 1'b0;
			sec_clk_tick <= 1'b0;
			multiplier_on <= 1'b0;
		end else begin
			dev_clk_tick <= (sw_state == SW_RUN) && old_tick;
			feature_clk_tick <= slow_tick;
			sec_clk_tick <= sec_tick;
			multiplier_on <= mult_active;
		end
	end

	// APB: ready one cycle after setup, so every transfer has one wait-free access
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end else begin
			pready <= psel & ~penable;
			if (psel && !penable) begin
				pslverr <= (paddr != `IOTPC_OFF_TUNING) && (paddr != `IOTPC_OFF_OSCCTL) &&
					(paddr != `IOTPC_OFF_STATUS);
				case (paddr)
					`IOTPC_OFF_TUNING: prdata <= {24'h000000, low_freq_source_sel,
						multiplier_enable & mult_avail, 1'b0, freq_trim_field};
					`IOTPC_OFF_OSCCTL: prdata <= {25'h0000000, internal_freq_sel, 2'h0,
						system_clock_sel};
					`IOTPC_OFF_STATUS: prdata <= {27'h0000000, mult_avail,
						sw_state != SW_RUN, active_src, mult_active};
					default: prdata <= 32'h00000000;
				endcase
			end
		end
	end

endmodule // iotpc_top

// [rtl/iotpc_defines.vh]
/*
 * Offsets, field positions, reset values, codes and timing counts of the
 * internal oscillator tuning and multiplier control block.
 * Assumes inclusion by bare name from the block's design file.
 */
`ifndef IOTPC_DEFINES_VH
`define IOTPC_DEFINES_VH

// APB register byte offsets
`define IOTPC_OFF_TUNING 8'h00
`define IOTPC_OFF_OSCCTL 8'h04
`define IOTPC_OFF_STATUS 8'h08

// Tuning register fields
`define IOTPC_LFSRC_BIT 7
`define IOTPC_MULEN_BIT 6
`define IOTPC_TRIM_MSB 4
`define IOTPC_TUNING_RESET 8'h00

// Oscillator control register fields
`define IOTPC_FSEL_MSB 6
`define IOTPC_FSEL_LSB 4
`define IOTPC_SYSSEL_MSB 1
`define IOTPC_FSEL_RESET 3'h4
`define IOTPC_SYSSEL_RESET 2'h0

// Frequency select codes
`define IOTPC_FSEL_8MHZ 3'h7
`define IOTPC_FSEL_4MHZ 3'h6
`define IOTPC_FSEL_31KHZ 3'h0

// Primary clock configuration codes selecting the internal block
`define IOTPC_CFG_INT_A 4'h9
`define IOTPC_CFG_INT_B 4'h8

// Source indices
`define IOTPC_SRC_PRI 2'h0
`define IOTPC_SRC_SEC 2'h1
`define IOTPC_SRC_INT 2'h2

// Behavioural oscillator model: 16-bit phase accumulator at the system clock
`define IOTPC_FAST_INC 16'h0a3d
`define IOTPC_TRIM_STEP 16'h000a
`define IOTPC_MULT_FACTOR 16'h0004

// Timing
`define IOTPC_CLK_MHZ 200
`define IOTPC_SLOW_HZ 31000
`define IOTPC_SLOW_DIV ((`IOTPC_CLK_MHZ * 1000000) / `IOTPC_SLOW_HZ)
`define IOTPC_TRIM_TICKS 8
`define IOTPC_SETTLE_NS 1000000
`define IOTPC_SETTLE_CYC ((`IOTPC_SETTLE_NS * `IOTPC_CLK_MHZ) / 1000)
`define IOTPC_SW_OLD_TICKS 2
`define IOTPC_SW_NEW_TICKS 3

`endif

// [sim/iotpc_monitor.sv]
/* Checker of the tuning block's APB and clock-enable ports.
   Assumes it is bound to every instance of the top module. */
`timescale 1ns/100ps
module iotpc_monitor #(
	parameter SLOW_DIV = 20,
	parameter SETTLE_CYC = 50
) (
	input wire clk, // Clock
	input wire rst_n, // Reset
	input wire psel, // APB select
	input wire penable, // APB enable
	input wire pwrite, // APB direction
	input wire [7:0] paddr, // APB address
	input wire [31:0] prdata, // APB read data
	input wire pready, // APB ready
	input wire pslverr, // APB error
	input wire [3:0] primary_clock_cfg, // Primary config
	input wire secondary_timer_osc_tick, // Secondary tick in
	input wire secondary_osc_en, // Secondary enable
	input wire feature_clk_tick, // Feature tick
	input wire sec_clk_tick, // Secondary tick out
	input wire multiplier_on // Multiplier active
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	wire setup = psel && !penable;
	wire mapped = paddr == 8'h00 || paddr == 8'h04 || paddr == 8'h08;
	wire cfg_int = primary_clock_cfg == 4'h9 || primary_clock_cfg == 4'h8;
	wire tune_rd = pready && !pwrite && paddr == 8'h00;
	a_ready_follows: assert property (setup |=> pready) else $error("No ready after setup");
	a_ready_origin: assert property (pready |-> $past(setup)) else $error("Ready without setup");
	a_err_unmapped: assert property (setup |=> pslverr == !$past(mapped)) else $error("Wrong error response");
	a_err_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0) else $error("Error read not zero");
	a_tune_gap: assert property (tune_rd |-> prdata[5] == 1'h0 && prdata[31:8] == 24'h0) else $error("Gap bit set");
	a_mult_bit_ro: assert property ((!cfg_int) [*3] ##0 tune_rd |-> !prdata[6]) else $error("Enable bit readable");
	a_mult_cfg: assert property ((!cfg_int) [*3] |-> !multiplier_on) else $error("Multiplier without config");
	a_sec_gated: assert property (sec_clk_tick |-> $past(secondary_timer_osc_tick && secondary_osc_en)) else $error("Bad sec tick");
	a_feature_gap: assert property (feature_clk_tick |=> !feature_clk_tick [*8]) else $error("Feature tick too close");
	c_tune_write: cover property (setup && pwrite && paddr == 8'h00);
	c_err: cover property (pready && pslverr);
	c_mult: cover property ($rose(multiplier_on));
endmodule // iotpc_monitor
bind iotpc_top iotpc_monitor #(.SLOW_DIV(SLOW_DIV), .SETTLE_CYC(SETTLE_CYC)) iotpc_monitor_i (.clk(clk), .rst_n(rst_n),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.primary_clock_cfg(primary_clock_cfg), .secondary_timer_osc_tick(secondary_timer_osc_tick),
	.secondary_osc_en(secondary_osc_en), .feature_clk_tick(feature_clk_tick), .sec_clk_tick(sec_clk_tick),
	.multiplier_on(multiplier_on));

// [sim/iotpc_top_bench.sv]
/* Self-checking bench for the tuning block with a register model.
   Assumes the checker is bound from its own file. */
`timescale 1ns/100ps
module iotpc_top_bench;
	localparam SD = 20;
	reg clk = 1'h0, rst_n = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, er;
	reg [7:0] paddr = 8'h00;
	reg [31:0] pwdata = 32'h0, rd, d;
	reg [3:0] cfg = 4'h0;
	reg ptick = 1'h0, stick = 1'h0, sen = 1'h1, sec_exp = 1'h0;
	wire [31:0] prdata;
	wire pready, pslverr, dtick, ftick, s_tick, mon;
	wire cint = cfg == 4'h9 || cfg == 4'h8;
	integer bad_count = 0, samples_checked = 0, cyc = 0, tun = 0, fs, i, k;
	iotpc_top #(.SLOW_DIV(SD), .SETTLE_CYC(50)) iotpc_top_i (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.primary_clock_cfg(cfg), .primary_osc_tick(ptick), .secondary_timer_osc_tick(stick),
		.secondary_osc_en(sen), .dev_clk_tick(dtick), .feature_clk_tick(ftick), .sec_clk_tick(s_tick),
		.multiplier_on(mon));
	always #2.5 clk = ~clk;
	always @(posedge clk) begin
		ptick <= $urandom % 4 == 0;
		stick <= $urandom % 16 == 0;
		sen <= $urandom % 8 != 0;
		// Secondary output is the gated tick one cycle late
		sec_exp <= rst_n & stick & sen;
		if (rst_n) begin
			samples_checked = samples_checked + 1;
			if (s_tick !== sec_exp) begin
				bad_count = bad_count + 1;
				$display("[FAIL] %0t secondary tick mismatch", $time);
			end
		end
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			bad_count = bad_count + 1;
			stop_test;
		end
	end
	task stop_test;
		begin
			$display("Checks %0d mismatches %0d", samples_checked, bad_count);
			if (bad_count == 0 && samples_checked > 0)
				$display("Regression OK");
			else
				$display("Regression broken");
			$finish;
		end
	endtask
	task check(input [31:0] got, input [31:0] exp);
		begin
			samples_checked = samples_checked + 1;
			if (got !== exp) begin
				bad_count = bad_count + 1;
				$display("[FAIL] %0t got %h expected %h", $time, got, exp);
			end
		end
	endtask
	// Setup starts one edge after any release, so no signal is set twice in a step
	task apb(input w, input [7:0] a, input [31:0] wd);
		begin
			@(posedge clk);
			psel <= 1'h1;
			pwrite <= w;
			paddr <= a;
			pwdata <= wd;
			@(posedge clk);
			penable <= 1'h1;
			@(posedge clk);
			// Values read at the edge are those from before its updates
			while (pready !== 1'h1)
				@(posedge clk);
			rd = prdata;
			er = pslverr;
			psel <= 1'h0;
			penable <= 1'h0;
		end
	endtask
	task wait_ft;
		begin
			k = 0;
			do begin
				@(posedge clk);
				#1;
				k = k + 1;
			end while (ftick !== 1'h1 && k < 200);
		end
	endtask
	initial begin
		void'($urandom(32'haeebdb3f));
		repeat (10) @(posedge clk);
		rst_n <= 1'h1;
		apb(1'h0, 8'h00, 32'h0);
		check(rd, 32'h0);
		apb(1'h0, 8'h04, 32'h0);
		check(rd, 32'h40);
		apb(1'h1, 8'h0c, 32'hff);
		check(er, 1'h1);
		apb(1'h0, 8'h0c, 32'h0);
		check(rd, 32'h0);
		$display("Test reset and map done");
		for (i = 0; i < 24; i = i + 1) begin
			cfg <= (i % 3 == 2) ? 4'($urandom) : {3'h4, i[0]};
			repeat (4) @(posedge clk);
			// Enable bit is dropped once the config no longer offers the multiplier
			if (!cint)
				tun = tun & 32'hbf;
			apb(1'h0, 8'h00, 32'h0);
			check(rd, tun);
			d = $urandom;
			apb(1'h1, 8'h00, d);
			tun = d & (cint ? 32'hdf : 32'h9f);
			fs = $urandom % 8;
			apb(1'h1, 8'h04, fs << 4);
			apb(1'h0, 8'h00, 32'h0);
			check(rd, tun);
			apb(1'h0, 8'h04, 32'h0);
			check(rd, fs << 4);
			repeat (4) @(posedge clk);
			check(mon, cint && tun[6] && fs > 5);
		end
		$display("Test tuning register done");
		for (i = 0; i < 2; i = i + 1) begin
			apb(1'h1, 8'h00, 32'h0f - i);
			wait_ft;
			wait_ft;
			check(k, SD);
		end
		apb(1'h1, 8'h04, 32'h72);
		apb(1'h0, 8'h08, 32'h0);
		for (i = 0; i < 100 && rd[2:1] !== 2'h2; i = i + 1)
			apb(1'h0, 8'h08, 32'h0);
		check(rd[3:1], 3'h2);
		// Slow source as device clock lines up with the feature tick
		apb(1'h1, 8'h04, 32'h02);
		wait_ft;
		check(dtick, 1'h1);
		apb(1'h1, 8'h04, 32'h71);
		apb(1'h0, 8'h08, 32'h0);
		for (i = 0; i < 100 && rd[2:1] !== 2'h1; i = i + 1)
			apb(1'h0, 8'h08, 32'h0);
		check(rd[3:1], 3'h1);
		$display("Test sources done");
		stop_test;
	end
endmodule // iotpc_top_bench
